// [rtl/prc_pkg.sv]
// Purpose: Constants for the pulse router and contact input block
// Assumes: APB slave, 32-bit data, one 250 MHz clock
// Notes: Register map, field positions, modes and reset values
//
// Overview of operation
// - One pulse output repeats flow input pulses
// - Output feeds the prover computer during proving
// - Channel mode reproduces every pulse of input n
// - Off mode keeps output inactive always
// - Auto mode passes pulses under prover control
// - Each contact input is dual-state or pulse
// - Dual-state reports open or closed equipment state
// - Pulse type totalizes meter pulses up to 50 Hz
// - Event on entering, leaving, or any change
// - Log flag gates events; alarm needs log
package prc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCH = 4;
    localparam int NDI = 4;
    localparam int CFG_W = 8;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DICFG = 8'h04;
    localparam logic [7:0] ADDR_DISTATE = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_CNT0 = 8'h14;
    localparam logic [7:0] ADDR_CNT_LAST = 8'h20;

    // ****************************************
    // Output modes and control fields
    // ****************************************
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_AUTO = 3'h1;
    localparam logic [2:0] ROUTE_INPUT_ONE = 3'h2;
    localparam logic [2:0] ROUTE_INPUT_TWO = 3'h3;
    localparam logic [2:0] ROUTE_INPUT_THREE = 3'h4;
    localparam logic [2:0] ROUTE_INPUT_FOUR = 3'h5;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ASRC_LSB = 4;

    // ****************************************
    // Contact input config byte, one per input
    // ****************************************
    localparam int CFG_TYPE = 0;
    localparam int CFG_NC = 1;
    localparam int CFG_EDGE_LSB = 2;
    localparam int CFG_LOG = 4;
    localparam int CFG_ALARM = 5;
    localparam logic [1:0] EDGE_ENTER = 2'h0;
    localparam logic [1:0] EDGE_EXIT = 2'h1;
    localparam logic [1:0] EDGE_ANY = 2'h2;

    // ****************************************
    // Reset values and rates
    // ****************************************
    localparam logic [2:0] RST_MODE = MODE_OFF;
    localparam logic [31:0] RST_DICFG = 32'h00000000;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam int CLK_HZ = 250000000;
    localparam int MAX_PULSE_HZ = 50;
endpackage : prc_pkg

// [rtl/prc_top.sv]
// Purpose: Pulse output router and contact inputs behind APB
// Assumes: Pulse, gate and contact pins asynchronous to REF_CLK; APB on REF_CLK
// Notes: Every output is a flip-flop; IRQ is a level
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module prc_top
    import prc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NCH-1:0] PULSE_IN,
    input wire logic PROVER_GATE,
    input wire logic [NDI-1:0] CONTACT_IN,
    output logic PULSE_OUT,
    output logic IRQ
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NCH-1:0] pin_s1;
        logic [NCH-1:0] pin_s2;
        logic gate_s1;
        logic gate_s2;
        logic [NDI-1:0] di_s1;
        logic [NDI-1:0] di_s2;
        logic [NDI-1:0] act;
        logic [2:0] mode;
        logic [1:0] asrc;
        logic [31:0] dicfg;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [NDI-1:0][31:0] cnt;
        logic pout;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } prc_state_t;

    prc_state_t s;
    prc_state_t next_s;

    logic [NDI-1:0] lvl;
    logic [NDI-1:0] ev;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic sel_pulse;
    logic acc;
    logic done;
    logic wr;
    logic is_cnt;
    logic [7:0] cnt_off;
    logic [1:0] cnt_idx;
    logic [31:0] cfg_wr;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;
        // Only the second stage is ever read by logic
        next_s.pin_s1 = PULSE_IN;
        next_s.pin_s2 = s.pin_s1;
        next_s.gate_s1 = PROVER_GATE;
        next_s.gate_s2 = s.gate_s1;
        next_s.di_s1 = CONTACT_IN;
        next_s.di_s2 = s.di_s1;

        // Output routing; no stretching, pin edges kept as seen
        unique case (s.mode)
            ROUTE_INPUT_ONE: sel_pulse = s.pin_s2[0];
            ROUTE_INPUT_TWO: sel_pulse = s.pin_s2[1];
            ROUTE_INPUT_THREE: sel_pulse = s.pin_s2[2];
            ROUTE_INPUT_FOUR: sel_pulse = s.pin_s2[3];
            MODE_AUTO: sel_pulse = s.pin_s2[s.asrc] & s.gate_s2;
            default: sel_pulse = 1'b0;
        endcase
        next_s.pout = sel_pulse;

        // Contact inputs
        set_bits = 8'h00;
        for (int i = 0; i < NDI; i++) begin
            lvl[i] = s.di_s2[i] ^ s.dicfg[i*CFG_W+CFG_NC];
            unique case (s.dicfg[i*CFG_W+CFG_EDGE_LSB +: 2])
                EDGE_ENTER: ev[i] = lvl[i] & ~s.act[i];
                EDGE_EXIT: ev[i] = ~lvl[i] & s.act[i];
                EDGE_ANY: ev[i] = lvl[i] ^ s.act[i];
                default: ev[i] = 1'b0;
            endcase
            if (s.dicfg[i*CFG_W+CFG_TYPE]) begin
                // Counts each entering edge only; 50 Hz is far below the sync rate
                ev[i] = 1'b0;
                if (lvl[i] & ~s.act[i]) begin
                    next_s.cnt[i] = s.cnt[i] + 32'h00000001;
                end
            end
            set_bits[i] = ev[i] & s.dicfg[i*CFG_W+CFG_LOG];
            set_bits[NDI+i] = ev[i] & s.dicfg[i*CFG_W+CFG_LOG]
                & s.dicfg[i*CFG_W+CFG_ALARM];
        end
        next_s.act = lvl;

        // APB slave: one wait state, answer on second access cycle
        acc = PSEL & PENABLE;
        done = acc & s.pready;
        wr = done & PWRITE;
        next_s.pready = acc & ~s.pready;
        cnt_off = PADDR - ADDR_CNT0;
        cnt_idx = cnt_off[3:2];
        is_cnt = (PADDR >= ADDR_CNT0) && (PADDR <= ADDR_CNT_LAST)
            && (PADDR[1:0] == 2'h0);
        clr_bits = 8'h00;

        // Alarm flag cannot stand without the log flag
        cfg_wr = PWDATA;
        for (int i = 0; i < NDI; i++) begin
            cfg_wr[i*CFG_W+CFG_ALARM] = PWDATA[i*CFG_W+CFG_ALARM]
                & PWDATA[i*CFG_W+CFG_LOG];
        end

        if (acc & ~s.pready) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h00000000;
            if (PADDR == ADDR_CTRL) begin
                next_s.prdata[CTRL_MODE_LSB +: 3] = s.mode;
                next_s.prdata[CTRL_ASRC_LSB +: 2] = s.asrc;
            end else if (PADDR == ADDR_DICFG) begin
                next_s.prdata = s.dicfg;
            end else if (PADDR == ADDR_DISTATE) begin
                next_s.prdata[NDI-1:0] = s.act;
            end else if (PADDR == ADDR_STAT) begin
                next_s.prdata[7:0] = s.stat;
            end else if (PADDR == ADDR_MASK) begin
                next_s.prdata[7:0] = s.mask;
            end else if (is_cnt) begin
                next_s.prdata = s.cnt[cnt_idx];
            end else begin
                next_s.pslverr = 1'b1;
            end
        end else if (done) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h00000000;
        end

        if (wr) begin
            if (PADDR == ADDR_CTRL) begin
                next_s.mode = PWDATA[CTRL_MODE_LSB +: 3];
                next_s.asrc = PWDATA[CTRL_ASRC_LSB +: 2];
            end else if (PADDR == ADDR_DICFG) begin
                next_s.dicfg = cfg_wr;
            end else if (PADDR == ADDR_STAT) begin
                clr_bits = PWDATA[7:0];
            end else if (PADDR == ADDR_MASK) begin
                next_s.mask = PWDATA[7:0];
            end else if (is_cnt) begin
                // Any write zeroes the total
                next_s.cnt[cnt_idx] = 32'h00000000;
            end
        end

        // A new event beats a clear in the same cycle
        next_s.stat = (s.stat & ~clr_bits) | set_bits;
        next_s.irq = |(next_s.stat & next_s.mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.mode <= RST_MODE;
            s.dicfg <= RST_DICFG;
            s.mask <= RST_MASK;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign PULSE_OUT = s.pout;
    assign IRQ = s.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence seq_ch1_rise;
        (s.mode == ROUTE_INPUT_ONE && $rose(PULSE_IN[0]))
            ##1 (s.mode == ROUTE_INPUT_ONE)[*2];
    endsequence

    sequence seq_ch4_fall;
        (s.mode == ROUTE_INPUT_FOUR && $fell(PULSE_IN[3]))
            ##1 (s.mode == ROUTE_INPUT_FOUR)[*2];
    endsequence

    sequence seq_auto_shut;
        !PROVER_GATE ##1 (s.mode == MODE_AUTO)[*2];
    endsequence

    sequence seq_auto_pass;
        (PROVER_GATE && PULSE_IN[0]) ##1
            (s.mode == MODE_AUTO && s.asrc == 2'h0)[*2];
    endsequence

    AST_CH1_REPEAT: assert property (seq_ch1_rise |=> PULSE_OUT)
        else $error("Channel one pulse not repeated");

    AST_CH4_RELEASE: assert property (seq_ch4_fall |=> !PULSE_OUT)
        else $error("Channel four pulse end not repeated");

    AST_OFF_QUIET: assert property (
        $past(s.mode) == MODE_OFF |-> !PULSE_OUT)
        else $error("Pulse output active in off mode");

    AST_OUT_SOURCE: assert property (
        $rose(PULSE_OUT) |-> $past(|PULSE_IN, 3))
        else $error("Pulse output without any input pulse");

    AST_AUTO_GATE: assert property (seq_auto_shut |=> !PULSE_OUT)
        else $error("Auto mode passed pulse with gate closed");

    AST_AUTO_PASS: assert property (seq_auto_pass |=> PULSE_OUT)
        else $error("Auto mode blocked pulse with gate open");

    AST_STATE_LEVEL: assert property (
        $past(s.dicfg[CFG_NC]) == s.dicfg[CFG_NC] |->
        s.act[0] == ($past(CONTACT_IN[0], 3) ^ s.dicfg[CFG_NC]))
        else $error("Contact state does not follow input");

    AST_DUAL_NOCOUNT: assert property (
        (!s.dicfg[CFG_TYPE] && !wr) |=> $stable(s.cnt[0]))
        else $error("Dual-state input changed its total");

    AST_PULSE_COUNT: assert property (
        (s.dicfg[CFG_W+CFG_TYPE] && !s.dicfg[CFG_W+CFG_NC] && !wr
            && s.di_s2[1] && !s.act[1])
        |=> s.cnt[1] == $past(s.cnt[1]) + 32'h00000001)
        else $error("Pulse input edge not counted");

    AST_EVENT_EDGE: assert property (
        $rose(s.stat[0]) |-> $past(!s.dicfg[CFG_TYPE]
            && s.dicfg[CFG_LOG] && (s.act[0] != lvl[0])))
        else $error("Event flag without dual-state edge");

    AST_ALARM_NEEDS_LOG: assert property (
        s.dicfg[CFG_ALARM] |-> s.dicfg[CFG_LOG])
        else $error("Alarm flag set while log flag clear");

    AST_NC_INVERT: assert property (
        (s.dicfg[CFG_NC] && !$past(CONTACT_IN[0], 3)
            && $stable(s.dicfg)) |-> s.act[0])
        else $error("Normally closed contact not inverted");

    AST_APB_ANSWER: assert property (
        (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
        else $error("APB answer late");

    // ****************************************
    // Event, interrupt and bus checks
    // ****************************************
    sequence seq_enter_seen;
        !s.dicfg[CFG_TYPE] && s.dicfg[CFG_LOG]
            && s.dicfg[CFG_EDGE_LSB +: 2] == EDGE_ENTER
            && !s.act[0] && lvl[0];
    endsequence

    sequence seq_exit_seen;
        !s.dicfg[2*CFG_W+CFG_TYPE] && s.dicfg[2*CFG_W+CFG_LOG]
            && s.dicfg[2*CFG_W+CFG_EDGE_LSB +: 2] == EDGE_EXIT
            && s.act[2] && !lvl[2];
    endsequence

    sequence seq_change_seen;
        !s.dicfg[3*CFG_W+CFG_TYPE] && s.dicfg[3*CFG_W+CFG_LOG]
            && s.dicfg[3*CFG_W+CFG_EDGE_LSB +: 2] == EDGE_ANY
            && s.act[3] != lvl[3];
    endsequence

    AST_ENTER_EVENT: assert property (seq_enter_seen |=> s.stat[0])
        else $error("Entry event not flagged");

    AST_ENTER_ALARM: assert property (
        (seq_enter_seen ##0 s.dicfg[CFG_ALARM]) |=> s.stat[NDI])
        else $error("Alarm event not flagged on entry");

    AST_EXIT_EVENT: assert property (seq_exit_seen |=> s.stat[2])
        else $error("Exit event not flagged");

    AST_ANY_EVENT: assert property (seq_change_seen |=> s.stat[3])
        else $error("Change event not flagged");

    AST_NOLOG_SILENT: assert property (
        !s.dicfg[CFG_LOG] |=> !$rose(s.stat[0]))
        else $error("Event flagged with log flag clear");

    AST_PULSE_SILENT: assert property (
        s.dicfg[CFG_W+CFG_TYPE]
        |=> !$rose(s.stat[1]) && !$rose(s.stat[NDI+1]))
        else $error("Pulse input raised an event");

    AST_STAT_STICKY: assert property (
        !(wr && PADDR == ADDR_STAT)
        |=> (s.stat & $past(s.stat)) == $past(s.stat))
        else $error("Event flag dropped without a clear");

    AST_IRQ_LEVEL: assert property (IRQ == |(s.stat & s.mask))
        else $error("Interrupt level does not match flags");

    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("APB ready held longer than one cycle");

    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("APB error shown without ready");

    AST_RDATA_IDLE: assert property (
        !PREADY |-> PRDATA == 32'h00000000)
        else $error("Read data shown outside the answer");

    AST_MODE_WRITE: assert property (
        (wr && PADDR == ADDR_CTRL)
        |=> s.mode == $past(PWDATA[CTRL_MODE_LSB +: 3]))
        else $error("Output mode write not taken");

    AST_CNT_CLEAR: assert property (
        (wr && is_cnt && cnt_idx == 2'h1)
        |=> s.cnt[1] == 32'h00000000)
        else $error("Pulse total not zeroed by write");
endmodule : prc_top

// [verif/prc_prover.sv]
// Purpose: Prover computer model at the repeated pulse output
// Assumes: Gate opens one edge after the bench asks for it
// Notes: Counts rising edges of the pulses it receives
`timescale 1ns/10ps
module prc_prover (
    input wire logic clk,
    input wire logic rst,
    input wire logic arm,
    input wire logic pulse_out,
    output logic gate,
    output logic [15:0] count
);
    logic last;
    // ********
    // Gate and tally
    // ********
    // Prover decides when pulses pass in auto mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate <= 1'b0;
            last <= 1'b0;
            count <= 16'h0000;
        end else begin
            gate <= arm;
            last <= pulse_out;
            if (pulse_out && !last) begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule : prc_prover

// [verif/test_pulse_route_and_contact_inputs.sv]
// Purpose: Self-checking bench for the pulse router block
// Assumes: One wait state APB slave, 250 MHz clock
// Notes: Route table first, then contact inputs by hand
`timescale 1ns/10ps
module test_pulse_route_and_contact_inputs
    import prc_pkg::*;
;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] src;
        logic [3:0] pin;
        logic arm;
        logic exp;
    } prc_row_t;
    prc_row_t rows [11] = '{
        '{MODE_OFF, 2'h0, 4'hF, 1'b1, 1'b0},
        '{ROUTE_INPUT_ONE, 2'h0, 4'h1, 1'b0, 1'b1},
        '{ROUTE_INPUT_ONE, 2'h0, 4'hE, 1'b0, 1'b0},
        '{ROUTE_INPUT_TWO, 2'h0, 4'h2, 1'b0, 1'b1},
        '{ROUTE_INPUT_THREE, 2'h0, 4'h4, 1'b0, 1'b1},
        '{ROUTE_INPUT_FOUR, 2'h0, 4'h8, 1'b0, 1'b1},
        '{ROUTE_INPUT_FOUR, 2'h0, 4'h7, 1'b0, 1'b0},
        '{MODE_AUTO, 2'h0, 4'h1, 1'b1, 1'b1},
        '{MODE_AUTO, 2'h0, 4'h1, 1'b0, 1'b0},
        '{MODE_AUTO, 2'h2, 4'h4, 1'b1, 1'b1},
        '{3'h6, 2'h0, 4'hF, 1'b1, 1'b0}};
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pin = 4'h0;
    logic [3:0] ci = 4'h0;
    logic arm = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, gate, pout, irq;
    logic [15:0] pcount, c0;
    int miscompares = 0;
    int cmp_count = 0;

    always #2 REF_CLK = ~REF_CLK;

    prc_top dut_u (.REF_CLK(REF_CLK), .RST(RST), .PADDR(paddr),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PULSE_IN(pin), .PROVER_GATE(gate),
        .CONTACT_IN(ci), .PULSE_OUT(pout), .IRQ(irq));
    prc_prover prover_u (.clk(REF_CLK), .rst(RST), .arm(arm),
        .pulse_out(pout), .gate(gate), .count(pcount));

    // ********
    // Tasks
    // ********
    task test_done();
        $display("comparisons %0d mismatches %0d", cmp_count,
            miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge REF_CLK);
        penable <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        if (n >= 40) begin
            chk(32'h0, 32'h1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    task wt(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask : wt

    initial begin
        #200000;
        miscompares++;
        test_done();
    end

    initial begin
        wt(10);
        chk({pout, irq}, 32'h0);
        wt(10);
        RST <= 1'b0;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_DICFG, RST_DICFG);
        rdchk(ADDR_MASK, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, ADDR_CTRL, {26'h0, rows[i].src, 1'b0, rows[i].mode});
            pin <= rows[i].pin;
            arm <= rows[i].arm;
            wt(6);
            chk(pout, rows[i].exp);
        end
        apb(1'b1, ADDR_CTRL, {29'h0, ROUTE_INPUT_ONE});
        pin <= 4'h0;
        wt(6);
        c0 = pcount;
        repeat (3) begin
            pin <= 4'h1;
            wt(4);
            pin <= 4'h0;
            wt(4);
        end
        wt(4);
        chk(pcount, c0 + 16'h0003);
        // Alarm on an unlogged input must read back cleared
        apb(1'b1, ADDR_DICFG, 32'h20140130);
        rdchk(ADDR_DICFG, 32'h00140130);
        apb(1'b1, ADDR_MASK, 32'h11);
        ci <= 4'h1;
        wt(6);
        chk(irq, 1'b1);
        rdchk(ADDR_STAT, 32'h11);
        rdchk(ADDR_DISTATE, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h11);
        wt(2);
        chk(irq, 1'b0);
        ci <= 4'hD;
        wt(6);
        rdchk(ADDR_STAT, 32'h0);
        ci <= 4'h9;
        wt(6);
        rdchk(ADDR_STAT, 32'h4);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_STAT, 32'h4);
        repeat (3) begin
            ci[1] <= 1'b1;
            wt(4);
            ci[1] <= 1'b0;
            wt(4);
        end
        wt(4);
        rdchk(ADDR_CNT0 + 8'h04, 32'h3);
        apb(1'b1, ADDR_CNT0 + 8'h04, 32'h00000000);
        rdchk(ADDR_CNT0 + 8'h04, 32'h0);
        rdchk(ADDR_STAT, 32'h0);
        apb(1'b1, ADDR_DICFG, 32'h00140132);
        wt(6);
        rdchk(ADDR_DISTATE, 32'h8);
        ci <= 4'h8;
        wt(6);
        rdchk(ADDR_DISTATE, 32'h9);
        chk(irq, 1'b1);
        // Input four on any change, logged, no alarm
        apb(1'b1, ADDR_STAT, 32'h11);
        apb(1'b1, ADDR_DICFG, 32'h18140132);
        ci <= 4'h0;
        wt(6);
        rdchk(ADDR_STAT, 32'h8);
        apb(1'b1, ADDR_STAT, 32'h8);
        ci <= 4'h8;
        wt(6);
        rdchk(ADDR_STAT, 32'h8);
        rdchk(8'h40, 32'h0);
        chk(er, 1'b1);
        // Reset in mid-run must restore the register defaults
        RST <= 1'b1;
        wt(4);
        chk({pout, irq}, 32'h0);
        RST <= 1'b0;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_MASK, 32'h0);
        rdchk(ADDR_DICFG, RST_DICFG);
        test_done();
    end
endmodule : test_pulse_route_and_contact_inputs
